// ==== core/dacr_defs.svh ====
// register offsets, reset values, field positions and timing in ns
// assumes: included by bare name from files under core/
`ifndef DACR_DEFS_SVH
`define DACR_DEFS_SVH

`define DACR_ADDR_PWR 7'h00
`define DACR_ADDR_FMT 7'h01
`define DACR_ADDR_DRV 7'h02
`define DACR_ADDR_TIM 7'h03
`define DACR_ADDR_TERMA 7'h04
`define DACR_ADDR_TERMB 7'h05
`define DACR_ADDR_DIVFMT 7'h06
`define DACR_ADDR_RSVD 7'h07
`define DACR_ADDR_CM 7'h08
`define DACR_ADDR_SOFT 7'h0a

`define DACR_RST_PWR 8'h03
`define DACR_RST_FMT 8'h00
`define DACR_RST_DRV 8'h00
`define DACR_RST_TIM 8'hb6
`define DACR_RST_TERM 8'h00
`define DACR_RST_DIVFMT 8'h00
`define DACR_RST_CM 8'h00
`define DACR_SOFT_KEY 8'h5a

// power nibble fields
`define DACR_PN_CHA_ON 0
`define DACR_PN_CHB_ON 1
`define DACR_PN_STBY 2
`define DACR_PN_ADDER 3
// output format fields
`define DACR_FMT_MUX 1
`define DACR_FMT_MERGE_SEL 2
`define DACR_FMT_REV_A 3
`define DACR_FMT_REV_B 4
// driver power fields
`define DACR_DRV_CLK_OFF 0
`define DACR_DRV_OVR_OFF 1
`define DACR_DRV_PD_LO 2
`define DACR_DRV_PD_HI 3
// timing fields
`define DACR_TIM_BYPASS 7
`define DACR_TIM_HALF 6
// status byte fields
`define DACR_ST_DLL 0
`define DACR_ST_FIXED1 2
`define DACR_ST_VALID 4
`define DACR_ST_BUSY 5

`define DACR_OHM_50 9'h032
`define DACR_OHM_75 9'h04b
`define DACR_OHM_100 9'h064
`define DACR_OHM_150 9'h096
`define DACR_OHM_300 9'h12c

`define DACR_CLK_PERIOD_NS 10
`define DACR_ROM_LOAD_NS 320

`endif

// ==== core/dacr_pkg.sv ====
// shared types of the dual adc control register bank
// assumes: nothing beyond a SystemVerilog compiler
package dacr_pkg;
   typedef logic [7:0] dacr_byte_t;
   typedef logic [9:0] dacr_sample_t;
   typedef enum logic [1:0] {
      DACR_PD_HIZ,
      DACR_PD_LOW,
      DACR_PD_HIGH
   } dacr_pd_drive_t;
endpackage

// ==== core/dacr_regs.sv ====
// control and status registers of a dual adc behind a 3-wire serial port
// assumes: sclk stops outside frames, cs_n high between accesses,
// samples arrive on clk, shutdown pin and dll lock are asynchronous
`timescale 1ns/100ps
`include "dacr_defs.svh"

module dacr_regs #(
   parameter int ROM_LOAD_CYCLES =
      (`DACR_ROM_LOAD_NS + `DACR_CLK_PERIOD_NS - 1) / `DACR_CLK_PERIOD_NS
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic sdio_in,
   output logic sdio_out,
   output logic sdio_oe_n,
   input wire logic power_state_select_pin,
   input wire logic dll_locked,
   input wire logic rom_checksum_ok,
   input wire logic [9:0] sample_a,
   input wire logic [9:0] sample_b,
   input wire logic overrange_a,
   input wire logic overrange_b,
   output logic chan_a_active,
   output logic chan_a_standby,
   output logic chan_b_active,
   output logic chan_b_standby,
   output logic adder_active,
   output logic [9:0] bus_a_data,
   output logic bus_a_oe_n,
   output logic [9:0] bus_b_data,
   output logic bus_b_oe_n,
   output logic overrange_output,
   output logic overrange_oe_n,
   output logic data_clock_output,
   output logic data_clock_oe_n,
   output logic aligner_bypass,
   output logic half_period_delay,
   output logic [2:0] data_clock_skew,
   output logic [2:0] data_skew,
   output logic [8:0] chan_a_clock_term_ohms,
   output logic [8:0] chan_a_data_term_ohms,
   output logic [7:0] chan_b_termination,
   output logic [7:0] divider_format_pattern,
   output logic [7:0] input_common_mode
);

   localparam logic [15:0] ROM_CNT_INIT = 16'(ROM_LOAD_CYCLES);

   function automatic logic [8:0] term_ohms(input logic [2:0] code);
      logic [8:0] r;
      r = `DACR_OHM_300;
      case (code)
         3'h0: r = `DACR_OHM_50;
         3'h1: r = `DACR_OHM_75;
         3'h2: r = `DACR_OHM_100;
         3'h3: r = `DACR_OHM_150;
         default: r = `DACR_OHM_300;
      endcase
      return r;
   endfunction

   // signed sixteenths; reserved code 100 falls back to no shift
   function automatic logic [2:0] skew_16ths(input logic [2:0] code);
      logic [2:0] r;
      r = 3'h0;
      case (code)
         3'h1: r = 3'h1;
         3'h2: r = 3'h2;
         3'h3: r = 3'h3;
         3'h5: r = 3'h7;
         3'h6: r = 3'h6;
         3'h7: r = 3'h5;
         default: r = 3'h0;
      endcase
      return r;
   endfunction

   function automatic dacr_pkg::dacr_sample_t rev10(
      input dacr_pkg::dacr_sample_t v, input logic en);
      dacr_pkg::dacr_sample_t r;
      r = v;
      if (en) begin
         for (int i = 0; i < 10; i++) begin
            r[i] = v[9 - i];
         end
      end
      return r;
   endfunction

   // ---------------- link side, on sclk ----------------
   logic [4:0] bit_cnt_q;
   logic [14:0] shift_q;
   logic wr_req_q;
   logic [6:0] hold_addr_q;
   dacr_pkg::dacr_byte_t hold_data_q;
   dacr_pkg::dacr_byte_t out_q;
   logic out_oe_n_q;
   dacr_pkg::dacr_byte_t rd_byte;
   logic [2:0] st_s1_q;
   logic [2:0] st_s2_q;
   dacr_pkg::dacr_byte_t pwr_q, fmt_q, drv_q, tim_q;
   dacr_pkg::dacr_byte_t terma_q, termb_q, divfmt_q, cm_q;
   dacr_pkg::dacr_byte_t status_q;

   // frame state is cleared by cs_n itself since sclk stops between frames
   always_ff @(posedge sclk or posedge cs_n) begin
      if (cs_n) begin
         bit_cnt_q <= 5'h00;
         shift_q <= 15'h0000;
         wr_req_q <= 1'b0;
      end else begin
         shift_q <= {shift_q[13:0], sdio_in};
         if (bit_cnt_q != 5'h10) begin
            bit_cnt_q <= bit_cnt_q + 5'h01;
         end
         if (bit_cnt_q == 5'h0f && !shift_q[14]) begin
            wr_req_q <= 1'b1;
         end
      end
   end

   // held past cs_n rising so the clk side reads stable words
   always_ff @(posedge sclk) begin
      if (!cs_n && bit_cnt_q == 5'h0f && !shift_q[14]) begin
         hold_addr_q <= shift_q[13:7];
         hold_data_q <= {shift_q[6:0], sdio_in};
      end
   end

   // status bits change on their own, so each crosses by two flops
   always_ff @(posedge sclk) begin
      st_s1_q <= {status_q[`DACR_ST_BUSY], status_q[`DACR_ST_VALID],
                  status_q[`DACR_ST_DLL]};
      st_s2_q <= st_s1_q;
   end

   // control bytes only change after an earlier frame's write,
   // so they are quasi-static when read here
   always_comb begin
      rd_byte = 8'h00;
      case (shift_q[6:0])
         `DACR_ADDR_PWR: rd_byte = pwr_q;
         `DACR_ADDR_FMT: rd_byte = fmt_q;
         `DACR_ADDR_DRV: rd_byte = drv_q;
         `DACR_ADDR_TIM: rd_byte = tim_q;
         `DACR_ADDR_TERMA: rd_byte = terma_q;
         `DACR_ADDR_TERMB: rd_byte = termb_q;
         `DACR_ADDR_DIVFMT: rd_byte = divfmt_q;
         `DACR_ADDR_CM: rd_byte = cm_q;
         `DACR_ADDR_SOFT: begin
            rd_byte = 8'h00;
            rd_byte[`DACR_ST_BUSY] = st_s2_q[2];
            rd_byte[`DACR_ST_VALID] = st_s2_q[1];
            rd_byte[`DACR_ST_DLL] = st_s2_q[0];
            rd_byte[`DACR_ST_FIXED1] = 1'b1;
         end
         default: rd_byte = 8'h00;
      endcase
   end

   always_ff @(negedge sclk or posedge cs_n) begin
      if (cs_n) begin
         out_q <= 8'h00;
         out_oe_n_q <= 1'b1;
      end else if (bit_cnt_q == 5'h08 && shift_q[7]) begin
         out_q <= rd_byte;
         out_oe_n_q <= 1'b0;
      end else begin
         out_q <= {out_q[6:0], 1'b0};
      end
   end

   assign sdio_out = out_q[7];
   assign sdio_oe_n = out_oe_n_q;

   // ---------------- register side, on clk ----------------
   logic [2:0] wr_sync_q;
   logic wr_edge;
   logic soft_reset;
   logic [15:0] rom_cnt_q;
   logic rom_valid_q;
   logic pin_s1_q, pin_s2_q, dll_s1_q, dll_s2_q;

   always_ff @(posedge clk) begin
      if (reset) begin
         wr_sync_q <= 3'h0;
      end else begin
         wr_sync_q <= {wr_sync_q[1:0], wr_req_q};
      end
   end

   assign wr_edge = wr_sync_q[1] && !wr_sync_q[2];
   assign soft_reset = wr_edge && hold_addr_q == `DACR_ADDR_SOFT &&
                       hold_data_q == `DACR_SOFT_KEY;

   always_ff @(posedge clk) begin
      if (reset || soft_reset) begin
         pwr_q <= `DACR_RST_PWR;
         fmt_q <= `DACR_RST_FMT;
         drv_q <= `DACR_RST_DRV;
         tim_q <= `DACR_RST_TIM;
         terma_q <= `DACR_RST_TERM;
         termb_q <= `DACR_RST_TERM;
         divfmt_q <= `DACR_RST_DIVFMT;
         cm_q <= `DACR_RST_CM;
      end else if (wr_edge) begin
         // reserved 07h and unmapped addresses drop the write
         case (hold_addr_q)
            `DACR_ADDR_PWR: pwr_q <= hold_data_q;
            `DACR_ADDR_FMT: fmt_q <= hold_data_q;
            `DACR_ADDR_DRV: drv_q <= hold_data_q;
            `DACR_ADDR_TIM: tim_q <= hold_data_q;
            `DACR_ADDR_TERMA: terma_q <= hold_data_q;
            `DACR_ADDR_TERMB: termb_q <= hold_data_q;
            `DACR_ADDR_DIVFMT: divfmt_q <= hold_data_q;
            `DACR_ADDR_CM: cm_q <= hold_data_q;
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         pin_s1_q <= 1'b0;
         pin_s2_q <= 1'b0;
         dll_s1_q <= 1'b0;
         dll_s2_q <= 1'b0;
      end else begin
         pin_s1_q <= power_state_select_pin;
         pin_s2_q <= pin_s1_q;
         dll_s1_q <= dll_locked;
         dll_s2_q <= dll_s1_q;
      end
   end

   // rom reload restarts on every reset, soft or hard
   always_ff @(posedge clk) begin
      if (reset || soft_reset) begin
         rom_cnt_q <= ROM_CNT_INIT;
         rom_valid_q <= 1'b0;
      end else if (rom_cnt_q != 16'h0000) begin
         rom_cnt_q <= rom_cnt_q - 16'h0001;
         if (rom_cnt_q == 16'h0001) begin
            rom_valid_q <= rom_checksum_ok;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         status_q <= 8'h00;
      end else begin
         status_q <= 8'h00;
         status_q[`DACR_ST_BUSY] <= rom_cnt_q != 16'h0000;
         status_q[`DACR_ST_VALID] <= rom_valid_q;
         status_q[`DACR_ST_DLL] <= dll_s2_q;
         status_q[`DACR_ST_FIXED1] <= 1'b1;
      end
   end

   // power state
   logic [3:0] nib;
   logic any_on;
   assign nib = pin_s2_q ? pwr_q[7:4] : pwr_q[3:0];
   assign any_on = nib[`DACR_PN_CHA_ON] || nib[`DACR_PN_CHB_ON];

   always_ff @(posedge clk) begin
      if (reset) begin
         chan_a_active <= 1'b0;
         chan_b_active <= 1'b0;
         chan_a_standby <= 1'b0;
         chan_b_standby <= 1'b0;
         adder_active <= 1'b0;
      end else if (nib[`DACR_PN_ADDER]) begin
         chan_a_active <= any_on;
         chan_b_active <= any_on;
         chan_a_standby <= !any_on && nib[`DACR_PN_STBY];
         chan_b_standby <= !any_on && nib[`DACR_PN_STBY];
         adder_active <= any_on;
      end else begin
         chan_a_active <= nib[`DACR_PN_CHA_ON];
         chan_b_active <= nib[`DACR_PN_CHB_ON];
         chan_a_standby <= !nib[`DACR_PN_CHA_ON] && nib[`DACR_PN_STBY];
         chan_b_standby <= !nib[`DACR_PN_CHB_ON] && nib[`DACR_PN_STBY];
         adder_active <= 1'b0;
      end
   end

   // data path
   logic [10:0] sum;
   dacr_pkg::dacr_sample_t avg, word_a, word_b;
   logic mux_en, merge_sel, phase_q, use_a, use_b;
   dacr_pkg::dacr_pd_drive_t pd_drive;

   assign sum = {1'b0, sample_a} + {1'b0, sample_b};
   assign avg = sum[10:1];
   assign mux_en = fmt_q[`DACR_FMT_MUX];
   assign merge_sel = fmt_q[`DACR_FMT_MERGE_SEL];

   always_comb begin
      pd_drive = dacr_pkg::DACR_PD_HIZ;
      case (drv_q[`DACR_DRV_PD_HI:`DACR_DRV_PD_LO])
         2'h1: pd_drive = dacr_pkg::DACR_PD_LOW;
         2'h3: pd_drive = dacr_pkg::DACR_PD_HIGH;
         default: pd_drive = dacr_pkg::DACR_PD_HIZ;
      endcase
   end

   always_comb begin
      word_a = sample_a;
      word_b = sample_b;
      use_a = chan_a_active;
      use_b = chan_b_active;
      if (adder_active) begin
         word_a = avg;
         word_b = avg;
         use_a = !merge_sel;
         use_b = merge_sel;
      end else if (mux_en) begin
         // first phase carries the selected bus's own channel
         word_a = (phase_q ^ merge_sel) ? sample_b : sample_a;
         word_b = word_a;
         use_a = !merge_sel && (chan_a_active || chan_b_active);
         use_b = merge_sel && (chan_a_active || chan_b_active);
      end
   end

   always_ff @(posedge clk) begin
      if (reset || !mux_en) begin
         phase_q <= 1'b0;
      end else begin
         phase_q <= !phase_q;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         bus_a_data <= 10'h000;
         bus_a_oe_n <= 1'b1;
      end else if (use_a) begin
         bus_a_data <= rev10(word_a, fmt_q[`DACR_FMT_REV_A]);
         bus_a_oe_n <= 1'b0;
      end else begin
         bus_a_data <= (pd_drive == dacr_pkg::DACR_PD_HIGH) ? 10'h3ff
                                                           : 10'h000;
         bus_a_oe_n <= pd_drive == dacr_pkg::DACR_PD_HIZ;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         bus_b_data <= 10'h000;
         bus_b_oe_n <= 1'b1;
      end else if (use_b) begin
         bus_b_data <= rev10(word_b, fmt_q[`DACR_FMT_REV_B]);
         bus_b_oe_n <= 1'b0;
      end else begin
         bus_b_data <= (pd_drive == dacr_pkg::DACR_PD_HIGH) ? 10'h3ff
                                                           : 10'h000;
         bus_b_oe_n <= pd_drive == dacr_pkg::DACR_PD_HIZ;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         overrange_output <= 1'b0;
         overrange_oe_n <= 1'b1;
         data_clock_output <= 1'b0;
         data_clock_oe_n <= 1'b1;
      end else begin
         overrange_output <= overrange_a || overrange_b;
         overrange_oe_n <= drv_q[`DACR_DRV_OVR_OFF];
         data_clock_output <= !data_clock_output;
         data_clock_oe_n <= drv_q[`DACR_DRV_CLK_OFF];
      end
   end

   // analog trims held in flops so the outputs are glitch free
   always_ff @(posedge clk) begin
      if (reset) begin
         aligner_bypass <= 1'b0;
         half_period_delay <= 1'b0;
         data_clock_skew <= 3'h0;
         data_skew <= 3'h0;
         chan_a_clock_term_ohms <= `DACR_OHM_50;
         chan_a_data_term_ohms <= `DACR_OHM_50;
         chan_b_termination <= 8'h00;
         divider_format_pattern <= 8'h00;
         input_common_mode <= 8'h00;
      end else begin
         aligner_bypass <= tim_q[`DACR_TIM_BYPASS];
         half_period_delay <= tim_q[`DACR_TIM_HALF] && !mux_en;
         data_clock_skew <= skew_16ths(tim_q[5:3]);
         data_skew <= skew_16ths(tim_q[2:0]);
         chan_a_clock_term_ohms <= term_ohms(terma_q[5:3]);
         chan_a_data_term_ohms <= term_ohms(terma_q[2:0]);
         chan_b_termination <= termb_q;
         divider_format_pattern <= divfmt_q;
         input_common_mode <= cm_q;
      end
   end

   // ---------------- checks ----------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   sequence seq_soft_write;
      soft_reset;
   endsequence
   sequence seq_rom_run;
      status_q[`DACR_ST_BUSY] [*2];
   endsequence

   AST_RESET_VALUES: assert property ($fell(reset) |->
      pwr_q == `DACR_RST_PWR && tim_q == `DACR_RST_TIM && fmt_q == 8'h00)
      else $error("reset values wrong");
   AST_SOFT_RESET: assert property (seq_soft_write |=>
      pwr_q == `DACR_RST_PWR && tim_q == `DACR_RST_TIM && drv_q == 8'h00)
      else $error("soft reset did not restore defaults");
   AST_ROM_BUSY: assert property (seq_soft_write |=> ##1 seq_rom_run)
      else $error("busy not shown during rom load");
   AST_ROM_VALID: assert property (status_q[`DACR_ST_BUSY] |->
      !status_q[`DACR_ST_VALID])
      else $error("valid shown while loading");
   AST_DLL_LOCK: assert property (dll_s2_q |=> status_q[`DACR_ST_DLL])
      else $error("dll lock not reported");
   AST_SELECT: assert property (pin_s2_q && !pwr_q[7] && pwr_q[4] |=>
      chan_a_active) else $error("high nibble not applied");
   AST_STANDBY: assert property (!nib[3] && !nib[0] && nib[2] |=>
      chan_a_standby && !chan_a_active)
      else $error("standby not entered");
   AST_ADDER: assert property (nib[3] && any_on |=>
      chan_a_active && chan_b_active && adder_active)
      else $error("adder mode not both active");
   AST_AVERAGE: assert property (adder_active && !merge_sel &&
      !fmt_q[`DACR_FMT_REV_A] |=> bus_a_data == $past(avg))
      else $error("average wrong");
   AST_HALF_MUX: assert property (mux_en |=> !half_period_delay)
      else $error("half delay active in merged mode");
   AST_CLK_OFF: assert property (drv_q[`DACR_DRV_CLK_OFF] |=>
      data_clock_oe_n) else $error("data clock driver not off");
   AST_PD_HIGH: assert property (!use_a &&
      pd_drive == dacr_pkg::DACR_PD_HIGH |=>
      !bus_a_oe_n && bus_a_data == 10'h3ff)
      else $error("powerdown drive high wrong");
   AST_WRITE: assert property (wr_edge && !soft_reset &&
      hold_addr_q == `DACR_ADDR_FMT |=> fmt_q == $past(hold_data_q))
      else $error("write not applied");

endmodule // dacr_regs

// ==== testbench/dacr_host.sv ====
// host-side model of the 3-wire serial port
// assumes: device samples sdio on sclk rise, drives read data after a fall
`timescale 1ns/100ps
module dacr_host (
   output logic sclk,
   output logic cs_n,
   output logic sdio_in,
   input wire logic sdio_out,
   input wire logic sdio_oe_n
);
   logic drv_q;

   // shared sdio wire: the device wins while its enable is low
   assign sdio_in = !sdio_oe_n ? sdio_out : drv_q;

   // a select edge at start clears the link logic before any frame
   initial begin
      sclk = 1'b0;
      cs_n = 1'b0;
      drv_q = 1'b0;
      #1 cs_n = 1'b1;
   end

   // callers never pass the reserved slot
   task automatic xfer(input logic rd, input logic [6:0] addr,
      input logic [7:0] wd, output logic [7:0] rdat);
      logic [15:0] sh;
      sh = {rd, addr, wd};
      rdat = 8'h00;
      cs_n = 1'b0;
      #15;
      for (int i = 15; i >= 0; i--) begin
         // released line toggles so a stale level never reads as data
         drv_q = (rd && i < 8) ? ~drv_q : sh[i];
         #15 sclk = 1'b1;
         if (i < 8) rdat = {rdat[6:0], sdio_in};
         #15 sclk = 1'b0;
      end
      #15 cs_n = 1'b1;
      drv_q = ~drv_q;
      // gap lets the clk side take the write
      #90;
   endtask
endmodule // dacr_host

// ==== testbench/dual_adc_control_registers_bench.sv ====
// self-checking bench of the dual adc control register bank
// assumes: core/ files and dacr_host compiled first
`timescale 1ns/100ps
module dual_adc_control_registers_bench;
   typedef struct packed {
      logic [6:0] a;
      logic [7:0] d;
      logic pin;
      logic [14:0] o;
   } dacr_row_t;
   // o: power flags, driver enables, bypass, half, clock skew, data skew
   localparam dacr_row_t ROWS [16] = '{
      '{7'h00, 8'h03, 1'b1, 15'h00b6}, '{7'h00, 8'h40, 1'b1, 15'h14b6},
      '{7'h00, 8'h51, 1'b1, 15'h24b6}, '{7'h00, 8'h51, 1'b0, 15'h20b6},
      '{7'h00, 8'h92, 1'b1, 15'h68b6}, '{7'h00, 8'h92, 1'b0, 15'h08b6},
      '{7'h00, 8'h0c, 1'b0, 15'h14b6}, '{7'h00, 8'h08, 1'b0, 15'h00b6},
      '{7'h00, 8'h03, 1'b0, 15'h28b6}, '{7'h02, 8'h03, 1'b0, 15'h2bb6},
      '{7'h03, 8'h4d, 1'b0, 15'h2b4f}, '{7'h01, 8'h02, 1'b0, 15'h2b0f},
      '{7'h03, 8'he4, 1'b0, 15'h2b80}, '{7'h03, 8'hff, 1'b0, 15'h2bad},
      '{7'h01, 8'h00, 1'b0, 15'h2bed}, '{7'h02, 8'h00, 1'b0, 15'h28ed}};
   localparam logic [2:0] TC [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
   localparam logic [8:0] TO [6] = '{9'h032, 9'h04b, 9'h064, 9'h096,
      9'h12c, 9'h12c};

   logic clk, reset, sclk, cs_n, sdio_in, sdio_out, sdio_oe_n;
   logic pin, dll, rom_ok;
   logic [9:0] sa, sb, bus_a_data, bus_b_data, v0;
   logic a_act, a_stby, b_act, b_stby, add_act, bus_a_oe_n, bus_b_oe_n;
   logic ovr_oe_n, dck_oe_n, bypass, half, ovr_a, ovr_b, ovr_out, dck_out;
   logic [2:0] ck_skew, dt_skew;
   logic [8:0] ck_ohm, dt_ohm;
   logic [14:0] obs;
   logic [7:0] rb, term_b, divfmt, cmode;
   int fails, checked;

   assign obs = {add_act, a_act, a_stby, b_act, b_stby, ovr_oe_n, dck_oe_n,
      bypass, half, ck_skew, dt_skew};

   dacr_host host (.sclk(sclk), .cs_n(cs_n), .sdio_in(sdio_in),
      .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n));

   dacr_regs #(.ROM_LOAD_CYCLES(64)) uut (.clk(clk), .reset(reset),
      .sclk(sclk), .cs_n(cs_n), .sdio_in(sdio_in), .sdio_out(sdio_out),
      .sdio_oe_n(sdio_oe_n), .power_state_select_pin(pin),
      .dll_locked(dll), .rom_checksum_ok(rom_ok), .sample_a(sa),
      .sample_b(sb), .overrange_a(ovr_a), .overrange_b(ovr_b),
      .chan_a_active(a_act), .chan_a_standby(a_stby),
      .chan_b_active(b_act), .chan_b_standby(b_stby),
      .adder_active(add_act), .bus_a_data(bus_a_data),
      .bus_a_oe_n(bus_a_oe_n), .bus_b_data(bus_b_data),
      .bus_b_oe_n(bus_b_oe_n), .overrange_output(ovr_out),
      .overrange_oe_n(ovr_oe_n), .data_clock_output(dck_out),
      .data_clock_oe_n(dck_oe_n), .aligner_bypass(bypass),
      .half_period_delay(half), .data_clock_skew(ck_skew),
      .data_skew(dt_skew), .chan_a_clock_term_ohms(ck_ohm),
      .chan_a_data_term_ohms(dt_ohm), .chan_b_termination(term_b),
      .divider_format_pattern(divfmt), .input_common_mode(cmode));

   task automatic check(input string n, input logic [15:0] got,
      input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", n, exp, got);
      end
   endtask

   task automatic test_done;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask

   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      logic [7:0] junk;
      host.xfer(1'b0, a, d, junk);
      settle(8);
   endtask

   task automatic rd(input logic [6:0] a, output logic [7:0] d);
      host.xfer(1'b1, a, 8'h00, d);
   endtask

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // about 50 us of frames expected, so four times that
   initial begin
      #200000;
      fails++;
      test_done();
   end

   initial begin
      reset = 1'b1;
      pin = 1'b0;
      dll = 1'b1;
      rom_ok = 1'b1;
      sa = 10'h000;
      sb = 10'h000;
      ovr_a = 1'b0;
      ovr_b = 1'b0;
      repeat (8) @(posedge clk);
      reset <= 1'b0;
      settle(70);
      for (int i = 0; i < 8; i++) begin
         rd(i == 7 ? 7'h08 : 7'(i), rb);
         check("default", 16'(rb), i == 0 ? 16'h0003 :
            i == 3 ? 16'h00b6 : 16'h0000);
      end
      rd(7'h0a, rb);
      check("status", 16'(rb), 16'h0015);
      wr(7'h09, 8'hff);
      rd(7'h09, rb);
      check("unmapped", 16'(rb), 16'h0000);
      foreach (ROWS[i]) begin
         @(posedge clk);
         pin <= ROWS[i].pin;
         wr(ROWS[i].a, ROWS[i].d);
         rd(ROWS[i].a, rb);
         check("readback", 16'(rb), 16'(ROWS[i].d));
         check("st", 16'(obs), 16'(ROWS[i].o));
      end
      for (int i = 0; i < 6; i++) begin
         wr(7'h04, {2'b00, TC[i], TC[5-i]});
         check("ck_term", 16'(ck_ohm), 16'(TO[i]));
         check("dt_term", 16'(dt_ohm), 16'(TO[5-i]));
      end
      // load time outlasts the next read, so busy is still visible
      wr(7'h03, 8'h00);
      wr(7'h0a, 8'h5a);
      rd(7'h0a, rb);
      check("busy", 16'(rb & 8'h20), 16'h0020);
      settle(80);
      rd(7'h03, rb);
      check("soft_def", 16'(rb), 16'h00b6);
      rd(7'h0a, rb);
      check("status", 16'(rb), 16'h0015);
      @(posedge clk);
      dll <= 1'b0;
      rom_ok <= 1'b0;
      wr(7'h0a, 8'h5a);
      settle(80);
      rd(7'h0a, rb);
      check("status", 16'(rb), 16'h0004);
      wr(7'h00, 8'h09);
      wr(7'h02, 8'h0c);
      @(posedge clk);
      sa <= 10'h3ff;
      sb <= 10'h001;
      settle(8);
      check("avg_a", 16'(bus_a_data), 16'h0200);
      check("idle_b", 16'({bus_b_oe_n, bus_b_data}), 16'h03ff);
      wr(7'h01, 8'h04);
      check("avg_b", 16'({bus_b_oe_n, bus_b_data}), 16'h0200);
      wr(7'h02, 8'h04);
      check("idle_a", 16'({bus_a_oe_n, bus_a_data}), 16'h0000);
      wr(7'h02, 8'h08);
      check("hiz_a", 16'(bus_a_oe_n), 16'h0001);
      wr(7'h00, 8'h03);
      wr(7'h01, 8'h18);
      @(posedge clk);
      sa <= 10'h001;
      sb <= 10'h003;
      settle(8);
      check("rev_a", 16'(bus_a_data), 16'h0200);
      check("rev_b", 16'(bus_b_data), 16'h0300);
      wr(7'h01, 8'h02);
      @(posedge clk);
      sa <= 10'h111;
      sb <= 10'h222;
      settle(8);
      v0 = bus_a_data;
      settle(1);
      check("mux", 16'(v0 ^ bus_a_data), 16'h0333);
      wr(7'h01, 8'h06);
      v0 = bus_b_data;
      settle(1);
      check("mux_b", 16'(v0 ^ bus_b_data), 16'h0333);
      check("mux_a_off", 16'(bus_a_oe_n), 16'h0001);
      @(posedge clk);
      ovr_b <= 1'b1;
      settle(2);
      check("ovr", 16'({ovr_oe_n, ovr_out}), 16'h0001);
      wr(7'h02, 8'h0a);
      check("ovr_off", 16'(ovr_oe_n), 16'h0001);
      rb[0] = dck_out;
      settle(1);
      check("dck_toggle", 16'(rb[0] ^ dck_out), 16'h0001);
      wr(7'h05, 8'h2a);
      wr(7'h06, 8'h4c);
      wr(7'h08, 8'h93);
      check("raw", 16'({term_b, divfmt}), 16'h2a4c);
      check("raw_cm", 16'(cmode), 16'h0093);
      test_done();
   end
endmodule // dual_adc_control_registers_bench
